/* logic/sirs_top.sv */
// Position-settled qualifier, ramp set selector and manual speed selector.
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps
module sirs_top
    import sirs_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DEF
) (
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Motion state from the servo loops.
    input  wire logic [31:0] dev_scaled,
    input  wire logic [31:0] dev_pulse,
    input  wire logic [31:0] motor_speed,
    input  wire logic        homing,
    input  wire logic        cmd_buffer_empty,
    input  wire sirs_mode_e  op_mode,
    input  wire logic        analog_command_variant,
    input  wire sirs_ramp_s  entry_ramp,
    // Select pins from the host.
    input  wire logic        ramp_set_select,
    input  wire logic        speed_step_sel_0,
    input  wire logic        speed_step_sel_1,
    input  wire logic        speed_step_sel_2,
    // Cyclic command words.
    input  wire logic [31:0] cmd_word_10,
    input  wire logic [31:0] cmd_word_12,
    // Results.
    output logic             position_settled_out,
    output logic             zero_deviation_out,
    output logic             zero_speed_out,
    output sirs_ramp_s       ramp_time,
    output logic [31:0]      speed_command,
    output logic [31:0]      deviation_monitor
);
    sirs_ctrl_s  ctrl;
    logic [17:0] range_set;
    logic [9:0]  pulse_set;
    logic [9:0]  judge_set;
    sirs_ramp_s  ramp1;
    sirs_ramp_s  ramp2;
    logic [31:0] zspd_set;
    logic [31:0] tqmax_set;
    logic [31:0] feed [1:7];
    logic        fmt_pulse;
    logic        fmt_loaded;

    // Pin synchronisers: three stages, accepted when the last two agree.
    logic [3:0] pin_raw;
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] pin;
    assign pin_raw = {speed_step_sel_2, speed_step_sel_1,
                      speed_step_sel_0, ramp_set_select};
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    s1[gi]  <= 1'b0;
                    s2[gi]  <= 1'b0;
                    s3[gi]  <= 1'b0;
                    pin[gi] <= 1'b0;
                end else begin
                    s1[gi] <= pin_raw[gi];
                    s2[gi] <= s1[gi];
                    s3[gi] <= s2[gi];
                    if (s2[gi] == s3[gi]) begin
                        pin[gi] <= s3[gi];
                    end
                end
            end
        end
    endgenerate

    // Bus decode. Reads are captured in the setup cycle, so every
    // access completes with no wait state.
    logic       setup;
    logic       wr;
    logic       feed_hit;
    logic [2:0] feed_idx;
    logic       hit;
    logic [7:0] feed_off;
    assign setup    = psel && !penable;
    assign wr       = psel && penable && pwrite;
    assign feed_off = paddr - A_FEED1;
    assign feed_idx = feed_off[4:2] + 3'h1;
    assign feed_hit = (paddr >= A_FEED1) && (paddr < A_TQMAX)
                      && (paddr[1:0] == 2'h0);
    assign hit = feed_hit || paddr inside {A_CTRL, A_RANGE, A_PULSE,
                 A_JUDGE, A_RAMP0, A_RAMP0 + 8'h04, A_RAMP0 + 8'h08,
                 A_RAMP0 + 8'h0C, A_ZSPD, A_TQMAX, A_STATUS, A_DEVMON};
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;

    logic qual;
    logic judged;
    logic zdev;
    logic zspd;
    logic [31:0] status_word;
    logic [31:0] rd_mux;
    assign status_word = {26'h000_0000, fmt_loaded, fmt_pulse, judged,
                          zspd, zdev, position_settled_out};
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (feed_hit) begin
            rd_mux = feed[feed_idx];
        end else begin
            case (paddr)
                A_CTRL:           rd_mux = {28'h000_0000, ctrl};
                A_RANGE:          rd_mux = {14'h0000, range_set};
                A_PULSE:          rd_mux = {22'h00_0000, pulse_set};
                A_JUDGE:          rd_mux = {22'h00_0000, judge_set};
                A_RAMP0:          rd_mux = {12'h000, ramp1.accel};
                A_RAMP0 + 8'h04:  rd_mux = {12'h000, ramp1.decel};
                A_RAMP0 + 8'h08:  rd_mux = {12'h000, ramp2.accel};
                A_RAMP0 + 8'h0C:  rd_mux = {12'h000, ramp2.decel};
                A_ZSPD:           rd_mux = zspd_set;
                A_TQMAX:          rd_mux = tqmax_set;
                A_STATUS:         rd_mux = status_word;
                A_DEVMON:         rd_mux = deviation_monitor;
                default:          rd_mux = 32'h0000_0000;
            endcase
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            prdata <= rd_mux;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl      <= '0;
            range_set <= RANGE_RST;
            pulse_set <= PULSE_RST;
            judge_set <= JUDGE_RST;
            ramp1     <= {RAMP1_RST, RAMP1_RST};
            ramp2     <= {RAMP2_RST, RAMP2_RST};
            zspd_set  <= ZSPD_RST;
            tqmax_set <= TQMAX_RST;
            feed[1]   <= FEED_LO;
            feed[2]   <= FEED_MID;
            feed[3]   <= FEED_HI;
            for (int i = 4; i <= 7; i++) begin
                feed[i] <= FEED_LO;
            end
        end else if (wr) begin
            if (feed_hit) begin
                feed[feed_idx] <= pwdata;
            end
            case (paddr)
                A_CTRL:          ctrl <= pwdata[3:0];
                A_RANGE:         range_set <= pwdata[17:0];
                A_PULSE:         pulse_set <= pwdata[9:0];
                A_JUDGE:         judge_set <= pwdata[9:0];
                A_RAMP0:         ramp1.accel <= pwdata[19:0];
                A_RAMP0 + 8'h04: ramp1.decel <= pwdata[19:0];
                A_RAMP0 + 8'h08: ramp2.accel <= pwdata[19:0];
                A_RAMP0 + 8'h0C: ramp2.decel <= pwdata[19:0];
                A_ZSPD:          zspd_set <= pwdata;
                A_TQMAX:         tqmax_set <= pwdata;
                default:         ;
            endcase
        end
    end

    // The chosen format is kept through presetn, as a setting survives a power
    // cycle. Only the copy taken after reset drives the output, so a write
    // never changes the output format while running.
    sirs_ctrl_s wr_ctrl;
    logic       ctrl_wr;
    logic       fmt_keep = 1'b0;
    assign wr_ctrl = pwdata[3:0];
    assign ctrl_wr = wr && (paddr == A_CTRL);
    always_ff @(posedge pclk) begin
        if (ctrl_wr) begin
            fmt_keep <= wr_ctrl.settled_output_format;
        end
    end

    // The output format is taken once, in the first cycle after reset,
    // so a later write only shows after the next reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fmt_loaded <= 1'b0;
            fmt_pulse  <= 1'b0;
        end else if (!fmt_loaded) begin
            fmt_loaded <= 1'b1;
            fmt_pulse  <= fmt_keep;
        end
    end

    // Deviation and speed windows.
    logic [31:0] dev_sel;
    logic [31:0] dev_abs;
    logic [31:0] spd_abs;
    assign dev_sel = ctrl.deviation_unit_setting ? dev_pulse : dev_scaled;
    assign dev_abs = dev_sel[31] ? 32'(-dev_sel) : dev_sel;
    assign spd_abs = motor_speed[31] ? 32'(-motor_speed) : motor_speed;
    assign zdev = dev_abs <= {14'h0000, range_set};
    assign zspd = spd_abs <= zspd_set;
    assign qual = zdev && zspd && (!homing || cmd_buffer_empty);

    // Judgment timing: the millisecond base restarts with the condition.
    logic [$clog2(MS_CYCLES)-1:0] jsub;
    logic [9:0] jcnt;
    logic       jtick;
    assign jtick  = jsub == ($clog2(MS_CYCLES))'(MS_CYCLES - 1);
    assign judged = qual && (jcnt >= judge_set);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            jsub <= '0;
            jcnt <= '0;
        end else if (!qual) begin
            jsub <= '0;
            jcnt <= '0;
        end else begin
            jsub <= jtick ? '0 : jsub + 1'b1;
            if (jtick && jcnt < judge_set) begin
                jcnt <= jcnt + 10'h001;
            end
        end
    end

    // Single-pulse sequencer.
    sirs_so_e   so_st;
    sirs_so_e   next_so_st;
    logic       judged_q;
    logic       rise;
    logic [9:0] pcnt;
    logic [$clog2(MS_CYCLES)-1:0] psub;
    logic       pdone;
    assign rise  = judged && !judged_q;
    assign pdone = (pcnt <= 10'h001)
                   && (psub == ($clog2(MS_CYCLES))'(MS_CYCLES - 1));
    always_comb begin
        next_so_st = so_st;
        unique case (so_st)
            SO_IDLE:  if (fmt_pulse && rise) next_so_st = SO_PULSE;
            SO_PULSE: if (pdone) next_so_st = SO_IDLE;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            so_st    <= SO_IDLE;
            judged_q <= 1'b0;
            pcnt     <= '0;
            psub     <= '0;
        end else begin
            so_st    <= next_so_st;
            judged_q <= judged;
            if (so_st == SO_IDLE) begin
                pcnt <= pulse_set;
                psub <= '0;
            end else if (psub == ($clog2(MS_CYCLES))'(MS_CYCLES - 1)) begin
                psub <= '0;
                pcnt <= pcnt - 10'h001;
            end else begin
                psub <= psub + 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            position_settled_out <= 1'b0;
            zero_deviation_out   <= 1'b0;
            zero_speed_out       <= 1'b0;
            deviation_monitor    <= 32'h0000_0000;
        end else begin
            position_settled_out <= fmt_pulse ? (next_so_st == SO_PULSE)
                                              : judged;
            zero_deviation_out   <= zdev;
            zero_speed_out       <= zspd;
            deviation_monitor    <= dev_sel;
        end
    end

    // Ramp selection. A zero ramp output means no ramp is applied.
    // Ramp times are full-scale figures for 0 to 2000 r/min.
    logic       ramp_on;
    logic       spd_like;
    sirs_ramp_s ramp_sel;
    sirs_ramp_s ramp_use;
    assign spd_like = (op_mode == MODE_SPEED) || (op_mode == MODE_TORQUE);
    assign ramp_on  = (op_mode == MODE_INTPOS) || (op_mode == MODE_PROFILE)
                      || (analog_command_variant && spd_like
                          && ctrl.speed_ramp_enable);
    assign ramp_sel = pin[0] ? ramp2 : ramp1;
    assign ramp_use.accel = (op_mode == MODE_INTPOS && entry_ramp.accel != '0)
                            ? entry_ramp.accel : ramp_sel.accel;
    assign ramp_use.decel = (op_mode == MODE_INTPOS && entry_ramp.decel != '0)
                            ? entry_ramp.decel : ramp_sel.decel;

    // Speed selection.
    logic [2:0]  step;
    logic [31:0] word;
    logic [31:0] spd_next;
    logic [31:0] feed_sel;
    assign step = pin[3:1];
    assign feed_sel = feed[step];
    assign word = analog_command_variant ? cmd_word_12 : cmd_word_10;
    assign spd_next = (analog_command_variant && op_mode == MODE_TORQUE)
                      ? (ctrl.torque_limit_source ? cmd_word_12 : tqmax_set)
                      : ((step == 3'h0) ? word : feed_sel);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ramp_time     <= '0;
            speed_command <= 32'h0000_0000;
        end else begin
            ramp_time     <= (ramp_on && op_mode != MODE_PULSE) ? ramp_use : '0;
            speed_command <= spd_next;
        end
    end

    // Checks.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Output registers still hold reset values at the first edge after release.
    unit_select_a: assert property ($past(presetn) |->
            deviation_monitor == $past(dev_sel))
        else $error("deviation monitor ignores unit setting");
    zero_dev_a: assert property ($past(presetn) |->
            zero_deviation_out == ($past(dev_abs) <= {14'h0000, $past(range_set)}))
        else $error("zero deviation output wrong");
    zero_speed_a: assert property ($past(presetn) |->
            zero_speed_out == ($past(spd_abs) <= $past(zspd_set)))
        else $error("zero speed output wrong");
    qual_and_a: assert property (judged |-> zdev && zspd)
        else $error("settled without both windows");
    homing_drain_a: assert property (homing && !cmd_buffer_empty |-> !judged)
        else $error("settled while homing pulses remain");
    judge_time_a: assert property ($rose(judged) |->
            jcnt >= judge_set && (judge_set == 10'h000 || $past(qual)))
        else $error("judgment time not honoured");
    level_fmt_a: assert property (presetn && !fmt_pulse |=>
            position_settled_out == $past(judged))
        else $error("level format does not follow");
    fmt_latch_a: assert property (fmt_loaded |=> $stable(fmt_pulse))
        else $error("format changed while running");
    pulse_once_a: assert property (so_st == SO_PULSE && !pdone |=> so_st == SO_PULSE)
        else $error("pulse cut short");
    pulse_start_a: assert property (fmt_pulse && rise && so_st == SO_IDLE |=>
            position_settled_out)
        else $error("pulse did not start");
    pulse_end_a: assert property (so_st == SO_PULSE && pdone |=>
            !position_settled_out)
        else $error("pulse did not end");
    ramp_set_a: assert property (presetn && op_mode == MODE_INTPOS && entry_ramp == '0 |=>
            ramp_time == ($past(pin[0]) ? $past(ramp2) : $past(ramp1)))
        else $error("wrong ramp set");
    pulse_train_a: assert property (op_mode == MODE_PULSE |=> ramp_time == '0)
        else $error("ramp used in pulse train operation");
    step_feed_a: assert property (presetn && op_mode == MODE_SPEED && step != 3'h0 |=>
            speed_command == $past(feed_sel))
        else $error("wrong feed speed");
    pulse_cov: cover property (fmt_pulse && $rose(position_settled_out));
    level_cov: cover property (!fmt_pulse && $fell(position_settled_out));
    ramp2_cov: cover property (ramp_on && pin[0]);
    torque_cov: cover property (op_mode == MODE_TORQUE && ctrl.torque_limit_source);
endmodule // sirs_top

/* logic/sirs_pkg.sv */
// Constants, types and register map for the settle/ramp/speed-select block.
// Summary of operation
// - Deviation unit: 0 scaled, 1 raw pulses.
// - Chosen unit applies to monitor and range.
// - Zero deviation when |deviation| within range.
// - Zero speed when speed within range.
// - Settled needs zero deviation and zero speed.
// - Homing also needs buffered pulses drained.
// - Condition must persist for judgment time.
// - Output format: level or single pulse.
// - Format change takes effect after reset.
// - Pulse stays on for pulse time.
// - Ramp time means 0 to 2000 r/min.
// - Select off: set 1; on: set 2.
// - Select change applies immediately.
// - No ramps under pulse train operation.
// - Analog variant speed ramp needs enable.
// - Internal position moves always use ramps.
// - Torque speed limit follows speed rules.
// - Profile operation uses selected ramps.
// - Zero entry ramp uses selected ramps.
// - Step code 0 word, 1-7 feed speeds.
// - Feed speed defaults 100, 500, 1000, 100.
// - Analog speed/position uses command word 12.
// - Analog torque limit: max or word 12.
// - Positioning variant uses command word 10.
package sirs_pkg;
    localparam int CLK_PERIOD_NS = 8;
    localparam int MS_TIME_NS    = 1_000_000;
    localparam int MS_CYCLES_DEF = MS_TIME_NS / CLK_PERIOD_NS;
    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_RANGE  = 8'h04;
    localparam logic [7:0] A_PULSE  = 8'h08;
    localparam logic [7:0] A_JUDGE  = 8'h0C;
    localparam logic [7:0] A_RAMP0  = 8'h10;
    localparam logic [7:0] A_ZSPD   = 8'h20;
    localparam logic [7:0] A_FEED1  = 8'h24;
    localparam logic [7:0] A_TQMAX  = 8'h40;
    localparam logic [7:0] A_STATUS = 8'h44;
    localparam logic [7:0] A_DEVMON = 8'h48;
    localparam logic [17:0] RANGE_RST = 18'h0_0064;
    localparam logic [9:0]  PULSE_RST = 10'h014;
    localparam logic [9:0]  JUDGE_RST = 10'h000;
    // Ramp times in 0.1 ms steps.
    localparam logic [19:0] RAMP1_RST = 20'h0_03E8;
    localparam logic [19:0] RAMP2_RST = 20'h0_1388;
    // Speeds in 0.01 r/min steps.
    localparam logic [31:0] ZSPD_RST  = 32'h0000_1388;
    localparam logic [31:0] FEED_LO   = 32'h0000_2710;
    localparam logic [31:0] FEED_MID  = 32'h0000_C350;
    localparam logic [31:0] FEED_HI   = 32'h0001_86A0;
    localparam logic [31:0] TQMAX_RST = 32'h0007_A120;
    typedef struct packed {
        logic torque_limit_source;
        logic speed_ramp_enable;
        logic settled_output_format;
        logic deviation_unit_setting;
    } sirs_ctrl_s;
    typedef struct packed {
        logic [19:0] accel;
        logic [19:0] decel;
    } sirs_ramp_s;
    typedef enum logic [4:0] {
        MODE_INTPOS  = 5'h01,
        MODE_SPEED   = 5'h02,
        MODE_TORQUE  = 5'h04,
        MODE_PROFILE = 5'h08,
        MODE_PULSE   = 5'h10
    } sirs_mode_e;
    typedef enum logic [1:0] {
        SO_IDLE  = 2'h1,
        SO_PULSE = 2'h2
    } sirs_so_e;
endpackage

/* test/sirs_host.sv */
// Host controller model that drives the select pins and the cyclic command words.
`timescale 1ns/1ps
module sirs_host (
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Commands from the bench.
    input  wire logic        want_ramp,
    input  wire logic [2:0]  want_step,
    input  wire logic [31:0] want_w10,
    input  wire logic [31:0] want_w12,
    // Pins and words toward the block.
    output logic             ramp_set_select,
    output logic [2:0]       step_sel,
    output logic [31:0]      cmd_word_10,
    output logic [31:0]      cmd_word_12
);
    // The host changes its pins only just after a clock edge, at any moment of motion.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ramp_set_select <= 1'b0;
            step_sel        <= 3'h0;
            cmd_word_10     <= 32'h0000_0000;
            cmd_word_12     <= 32'h0000_0000;
        end else begin
            ramp_set_select <= want_ramp;
            step_sel        <= want_step;
            cmd_word_10     <= want_w10;
            cmd_word_12     <= want_w12;
        end
    end
endmodule // sirs_host

/* test/tb_top.sv */
// Self-checking bench for the settle, ramp select and speed select block.
`timescale 1ns/1ps
module tb_top;
    import sirs_pkg::*;
    localparam int MS = 4;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, dev_scaled, dev_pulse, motor_speed, w10, w12;
    logic [31:0] want_w10, want_w12, speed_command, deviation_monitor;
    logic        homing, cmd_buffer_empty, analog_command_variant, want_ramp, ramp_sel;
    logic [2:0]  want_step, step_sel;
    sirs_mode_e  op_mode;
    sirs_ramp_s  entry_ramp, ramp_time;
    logic        settled, zdev, zspd;
    int          n_mismatch, comparisons;
    logic [31:0] rd;
    logic        er;

    sirs_host sirs_host_i (.pclk(pclk), .presetn(presetn), .want_ramp(want_ramp),
        .want_step(want_step), .want_w10(want_w10), .want_w12(want_w12),
        .ramp_set_select(ramp_sel), .step_sel(step_sel), .cmd_word_10(w10),
        .cmd_word_12(w12));
    sirs_top #(.MS_CYCLES(MS)) sirs_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .dev_scaled(dev_scaled),
        .dev_pulse(dev_pulse), .motor_speed(motor_speed), .homing(homing),
        .cmd_buffer_empty(cmd_buffer_empty), .op_mode(op_mode),
        .analog_command_variant(analog_command_variant), .entry_ramp(entry_ramp),
        .ramp_set_select(ramp_sel), .speed_step_sel_0(step_sel[0]),
        .speed_step_sel_1(step_sel[1]), .speed_step_sel_2(step_sel[2]),
        .cmd_word_10(w10), .cmd_word_12(w12), .position_settled_out(settled),
        .zero_deviation_out(zdev), .zero_speed_out(zspd), .ramp_time(ramp_time),
        .speed_command(speed_command), .deviation_monitor(deviation_monitor));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic stop_test();
        if (n_mismatch == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    // One APB transfer; the request is held until pready is seen high at an edge.
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 50) n_mismatch++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic t_regs();
        logic [31:0] ev [0:16];
        ev = '{32'h0000_0000, 32'(RANGE_RST), 32'(PULSE_RST), 32'(JUDGE_RST),
               32'(RAMP1_RST), 32'(RAMP1_RST), 32'(RAMP2_RST), 32'(RAMP2_RST),
               ZSPD_RST, FEED_LO, FEED_MID, FEED_HI, FEED_LO, FEED_LO, FEED_LO,
               FEED_LO, TQMAX_RST};
        for (int i = 0; i < 17; i++) begin
            apb(8'(i * 4), 1'b0, 32'h0000_0000);
            chk({8'h00, rd}, {8'h00, ev[i]});
        end
        apb(8'h50, 1'b0, 32'h0000_0000);
        chk({39'h00_0000_0000, er}, 40'h00_0000_0001);
        apb(A_CTRL, 1'b1, 32'h0000_0002);
        apb(A_STATUS, 1'b0, 32'h0000_0000);
        chk({38'h0, rd[5:4]}, 40'h00_0000_0002);
        apb(A_CTRL, 1'b1, 32'h0000_0000);
    endtask

    task automatic t_dev();
        apb(A_CTRL, 1'b1, 32'h0000_0001);
        @(posedge pclk);
        dev_scaled <= 32'h0000_01F4; dev_pulse <= 32'hFFFF_FFFD;
        cyc(4);
        chk({39'h0, zdev}, 40'h1);
        chk({8'h0, deviation_monitor}, 40'h00_FFFF_FFFD);
        apb(A_DEVMON, 1'b0, 32'h0000_0000);
        chk({8'h0, rd}, 40'h00_FFFF_FFFD);
        apb(A_CTRL, 1'b1, 32'h0000_0000);
        cyc(4);
        chk({39'h0, zdev}, 40'h0);
        chk({8'h0, deviation_monitor}, 40'h00_0000_01F4);
    endtask

    task automatic t_settle();
        apb(A_JUDGE, 1'b1, 32'h0000_0002);
        @(posedge pclk);
        dev_scaled <= 32'hFFFF_FF9C; motor_speed <= 32'h0000_1770;
        cyc(20);
        chk({38'h0, zdev, zspd}, 40'h2);
        chk({39'h0, settled}, 40'h0);
        @(posedge pclk);
        motor_speed <= 32'hFFFF_EC78;
        cyc(4);
        chk({38'h0, zspd, settled}, 40'h2);
        cyc(10);
        chk({39'h0, settled}, 40'h1);
        @(posedge pclk);
        homing <= 1'b1; cmd_buffer_empty <= 1'b0;
        cyc(3);
        chk({39'h0, settled}, 40'h0);
        @(posedge pclk);
        cmd_buffer_empty <= 1'b1;
        cyc(14);
        chk({39'h0, settled}, 40'h1);
        @(posedge pclk);
        dev_scaled <= 32'h0000_0065;
        cyc(3);
        chk({38'h0, zdev, settled}, 40'h0);
    endtask

    task automatic rt(input sirs_mode_e m, input logic [39:0] exp);
        @(posedge pclk);
        op_mode <= m;
        cyc(10);
        chk(ramp_time, exp);
    endtask

    task automatic t_ramp();
        rt(MODE_INTPOS, {RAMP1_RST, RAMP1_RST});
        @(posedge pclk);
        want_ramp <= 1'b1;
        rt(MODE_INTPOS, {RAMP2_RST, RAMP2_RST});
        rt(MODE_PULSE, 40'h00_0000_0000);
        @(posedge pclk);
        analog_command_variant <= 1'b1;
        rt(MODE_SPEED, 40'h00_0000_0000);
        rt(MODE_TORQUE, 40'h00_0000_0000);
        rt(MODE_INTPOS, {RAMP2_RST, RAMP2_RST});
        apb(A_CTRL, 1'b1, 32'h0000_0004);
        rt(MODE_SPEED, {RAMP2_RST, RAMP2_RST});
        rt(MODE_TORQUE, {RAMP2_RST, RAMP2_RST});
        rt(MODE_PROFILE, {RAMP2_RST, RAMP2_RST});
        @(posedge pclk);
        entry_ramp <= {20'h0_0007, 20'h0_0009};
        rt(MODE_INTPOS, {20'h0_0007, 20'h0_0009});
        @(posedge pclk);
        entry_ramp <= '0;
        rt(MODE_INTPOS, {RAMP2_RST, RAMP2_RST});
    endtask

    task automatic sp(input logic [2:0] s, input sirs_mode_e m, input logic [31:0] exp);
        @(posedge pclk);
        want_step <= s; op_mode <= m;
        cyc(10);
        chk({8'h0, speed_command}, {8'h0, exp});
    endtask

    task automatic t_speed();
        logic [31:0] fd [0:7];
        fd = '{32'h0000_04D2, FEED_LO, FEED_MID, FEED_HI, FEED_LO, FEED_LO, FEED_LO,
               FEED_LO};
        @(posedge pclk);
        analog_command_variant <= 1'b0;
        want_w10 <= 32'h0000_04D2; want_w12 <= 32'h0000_162E;
        for (int s = 0; s < 8; s++) sp(3'(s), MODE_INTPOS, fd[s]);
        @(posedge pclk);
        analog_command_variant <= 1'b1;
        sp(3'h0, MODE_SPEED, 32'h0000_162E);
        sp(3'h2, MODE_SPEED, FEED_MID);
        apb(A_CTRL, 1'b1, 32'h0000_0000);
        sp(3'h0, MODE_TORQUE, TQMAX_RST);
        apb(A_CTRL, 1'b1, 32'h0000_0008);
        sp(3'h0, MODE_TORQUE, 32'h0000_162E);
    endtask

    // Pulse format takes hold only through a reset after the write.
    task automatic t_pulse();
        apb(A_CTRL, 1'b1, 32'h0000_0002);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        cyc(2);
        apb(A_STATUS, 1'b0, 32'h0000_0000);
        chk({38'h0, rd[5:4]}, 40'h3);
        @(posedge pclk);
        dev_scaled <= 32'h0000_0000;
        cyc(40);
        chk({38'h0, zdev, settled}, 40'h3);
        cyc(50);
        chk({38'h0, zdev, settled}, 40'h2);
    endtask

    initial begin
        #100_000;
        n_mismatch++;
        stop_test();
    end

    initial begin
        n_mismatch = 0; comparisons = 0; presetn = 1'b0;
        psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = '0;
        dev_scaled = '0; dev_pulse = '0; motor_speed = '0; homing = 1'b0;
        cmd_buffer_empty = 1'b1; op_mode = MODE_INTPOS; analog_command_variant = 1'b0;
        entry_ramp = '0; want_ramp = 1'b0; want_step = 3'h0; want_w10 = '0; want_w12 = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_dev();
        t_settle();
        t_ramp();
        t_speed();
        t_pulse();
        stop_test();
    end
endmodule // tb_top
